//--- rtl/output_compare_pwm_channel.sv
// Output compare channel with two time bases, pulse and PWM modes
`timescale 1ns/1ps
`include "oc_defs.svh"

module output_compare_pwm_channel
	import oc_pkg::*;
#(
	parameter int CHANNEL_NUMBER = 1
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Register port
	input  wire bus_req_t    bus_req,
	output logic [15:0]      bus_rdata,
	// Time base count ticks from the prescalers, and processor idle
	input  wire logic [1:0]  time_base_tick,
	input  wire logic        cpu_idle,
	// Fault pins, active low, asynchronous
	input  wire logic        fault_input_a_n,
	input  wire logic        fault_input_b_n,
	// Output pin and status
	output logic             compare_output_pin,
	output logic             compare_output_en,
	output logic             compare_interrupt_flag
);

	oc_state_t q;
	oc_state_t d;

	// Field-packed control register from the sixteen-bit value of a write
	function automatic ctl_t ctl_from_word(input logic [15:0] w,
		input logic fault_keep);
		ctl_t c;
		c.idle_halt_select   = w[`OC_CTL_IDLE_BIT];
		c.fault_status       = fault_keep;
		c.time_base_select   = w[`OC_CTL_TSEL_BIT];
		c.output_mode_select =
			oc_mode_t'(w[`OC_CTL_MODE_MSB:`OC_CTL_MODE_LSB]);
		return c;
	endfunction

	function automatic logic [15:0] ctl_to_word(input ctl_t c);
		logic [15:0] w;
		w = `OC_RST_WORD;
		w[`OC_CTL_IDLE_BIT]  = c.idle_halt_select;
		w[`OC_CTL_FAULT_BIT] = c.fault_status;
		w[`OC_CTL_TSEL_BIT]  = c.time_base_select;
		w[`OC_CTL_MODE_MSB:`OC_CTL_MODE_LSB] = c.output_mode_select;
		return w;
	endfunction

	function automatic logic is_pwm(input oc_mode_t m);
		return (m == MODE_PWM) || (m == MODE_PWM_FAULT);
	endfunction

	logic        wr_ctl;
	logic        wr_pri;
	logic        wr_sec;
	logic        wr_t2c;
	logic        wr_t2p;
	logic        wr_t3c;
	logic        wr_t3p;
	logic        wr_run;
	logic        wr_sts;
	logic [15:0] rd_word;
	logic [15:0] cnt_sel;
	logic        ev_sel;
	logic        wrap_sel;
	logic        halted;
	logic        fault_now;
	logic        pri_match;
	logic        sec_match;
	logic [15:0] duty_next;
	logic        flag_set;
	ctl_t        new_ctl;

	always_comb begin
		wr_ctl  = 1'b0;
		wr_pri  = 1'b0;
		wr_sec  = 1'b0;
		wr_t2c  = 1'b0;
		wr_t2p  = 1'b0;
		wr_t3c  = 1'b0;
		wr_t3p  = 1'b0;
		wr_run  = 1'b0;
		wr_sts  = 1'b0;
		rd_word = `OC_RST_WORD;
		if (bus_req.addr == `OC_OFF_CONTROL) begin
			wr_ctl  = bus_req.wr;
			rd_word = ctl_to_word(q.ctl);
		end else if (bus_req.addr == `OC_OFF_PRIMARY) begin
			wr_pri  = bus_req.wr;
			rd_word = q.primary_compare_value;
		end else if (bus_req.addr == `OC_OFF_SECONDARY) begin
			wr_sec  = bus_req.wr;
			rd_word = q.secondary_compare_value;
		end else if (bus_req.addr == `OC_OFF_T2_COUNT) begin
			wr_t2c  = bus_req.wr;
			rd_word = q.t2_count;
		end else if (bus_req.addr == `OC_OFF_T2_PERIOD) begin
			wr_t2p  = bus_req.wr;
			rd_word = q.t2_period;
		end else if (bus_req.addr == `OC_OFF_T3_COUNT) begin
			wr_t3c  = bus_req.wr;
			rd_word = q.t3_count;
		end else if (bus_req.addr == `OC_OFF_T3_PERIOD) begin
			wr_t3p  = bus_req.wr;
			rd_word = q.t3_period;
		end else if (bus_req.addr == `OC_OFF_TB_RUN) begin
			wr_run  = bus_req.wr;
			rd_word = {14'h0000, q.time_base_run};
		end else if (bus_req.addr == `OC_OFF_STATUS) begin
			wr_sts  = bus_req.wr;
			rd_word = {15'h0000, q.compare_interrupt_flag};
		end
	end

	always_comb begin
		d = q;

		// Read data appears in the cycle after the strobe only
		d.rdata = bus_req.rd ? rd_word : `OC_RST_WORD;

		// Two-stage synchronisers for the fault pins
		d.fault_sync1 = {fault_input_b_n, fault_input_a_n};
		d.fault_sync2 = q.fault_sync1;

		// Time bases count on their tick and wrap at period match
		d.tb_event = 2'b00;
		d.tb_wrap  = 2'b00;
		if (q.time_base_run[`OC_RUN_T2_BIT] && time_base_tick[0]) begin
			d.tb_event[0] = 1'b1;
			if (q.t2_count == q.t2_period) begin
				d.t2_count   = `OC_COUNT_WRAP;
				d.tb_wrap[0] = 1'b1;
			end else begin
				d.t2_count = q.t2_count + 16'h0001;
			end
		end
		if (q.time_base_run[`OC_RUN_T3_BIT] && time_base_tick[1]) begin
			d.tb_event[1] = 1'b1;
			if (q.t3_count == q.t3_period) begin
				d.t3_count   = `OC_COUNT_WRAP;
				d.tb_wrap[1] = 1'b1;
			end else begin
				d.t3_count = q.t3_count + 16'h0001;
			end
		end
		if (wr_t2c) begin
			d.t2_count = bus_req.wdata;
		end
		if (wr_t2p) begin
			d.t2_period = bus_req.wdata;
		end
		if (wr_t3c) begin
			d.t3_count = bus_req.wdata;
		end
		if (wr_t3p) begin
			d.t3_period = bus_req.wdata;
		end
		if (wr_run) begin
			d.time_base_run = bus_req.wdata[1:0];
		end

		// Selected time base; events are flagged in the same cycle the new count is held
		cnt_sel  = q.ctl.time_base_select ? q.t3_count : q.t2_count;
		ev_sel   = q.ctl.time_base_select ? q.tb_event[1] : q.tb_event[0];
		wrap_sel = q.ctl.time_base_select ? q.tb_wrap[1] : q.tb_wrap[0];
		halted   = q.ctl.idle_halt_select && cpu_idle;

		// Fault pin choice depends on which channel this is
		fault_now = (CHANNEL_NUMBER <= `OC_LAST_FAULT_A_CH) ?
			!q.fault_sync2[0] : !q.fault_sync2[1];

		// Equality tests once per count
		pri_match = ev_sel && !halted &&
			(cnt_sel == q.primary_compare_value);
		sec_match = ev_sel && !halted &&
			(cnt_sel == q.secondary_compare_value);
		flag_set  = 1'b0;
		duty_next = q.primary_compare_value;

		case (q.ctl.output_mode_select)
			MODE_OFF: begin
				d.pin    = 1'b0;
				d.pin_en = 1'b0;
			end
			MODE_FORCE_HIGH: begin
				if (pri_match) begin
					d.pin    = 1'b1;
					flag_set = 1'b1;
				end
			end
			MODE_FORCE_LOW: begin
				if (pri_match) begin
					d.pin    = 1'b0;
					flag_set = 1'b1;
				end
			end
			MODE_TOGGLE: begin
				if (pri_match) begin
					d.pin    = !q.pin;
					flag_set = 1'b1;
				end
			end
			MODE_SINGLE_PULSE, MODE_CONT_PULSE: begin
				case (q.pulse)
					PULSE_WAIT_RISE: begin
						if (pri_match) begin
							d.pin   = 1'b1;
							d.pulse = PULSE_WAIT_FALL;
						end
					end
					PULSE_WAIT_FALL: begin
						if (sec_match) begin
							d.pin    = 1'b0;
							flag_set = 1'b1;
							// Single pulse parks, continuous rearms
							d.pulse  = (q.ctl.output_mode_select ==
								MODE_CONT_PULSE) ? PULSE_WAIT_RISE
								: PULSE_DONE;
						end
					end
					PULSE_DONE: begin
						d.pin = 1'b0;
					end
					default: begin
						d.pulse = PULSE_WAIT_RISE;
					end
				endcase
			end
			default: begin
				// PWM: duty reloads from the secondary at the period wrap
				if (ev_sel && !halted) begin
					if (wrap_sel) begin
						duty_next = q.secondary_compare_value;
						d.primary_compare_value = duty_next;
					end
					// Covers zero, full and one-count-low duty cases
					d.pin = (cnt_sel < duty_next);
				end
				if (q.ctl.output_mode_select == MODE_PWM_FAULT &&
					fault_now) begin
					d.ctl.fault_status = 1'b1;
					flag_set = 1'b1;
				end else if (q.ctl.fault_status && !fault_now &&
					wrap_sel) begin
					// Hardware clears the fault at a period wrap of the selected time base once the pin is quiet
					d.ctl.fault_status = 1'b0;
				end
				// A faulted output is released until the fault clears
				d.pin_en = !d.ctl.fault_status;
				if (d.ctl.fault_status) begin
					d.pin = 1'b0;
				end
			end
		endcase

		// Register writes; control write re-initialises the pin
		if (wr_pri && !is_pwm(q.ctl.output_mode_select)) begin
			d.primary_compare_value = bus_req.wdata;
		end
		if (wr_sec) begin
			d.secondary_compare_value = bus_req.wdata;
		end
		if (wr_ctl) begin
			new_ctl = ctl_from_word(bus_req.wdata,
				q.ctl.fault_status);
			if (!(new_ctl.output_mode_select == MODE_PWM_FAULT)) begin
				// Fault status is meaningful only in mode 111
				new_ctl.fault_status = 1'b0;
			end
			d.ctl    = new_ctl;
			d.pulse  = PULSE_WAIT_RISE;
			d.pin_en = (new_ctl.output_mode_select != MODE_OFF);
			// High start only for mode 010 (forced low); other modes start low, except a write that stays in PWM
			d.pin    = (new_ctl.output_mode_select ==
				MODE_FORCE_LOW);
			if (is_pwm(new_ctl.output_mode_select) &&
				is_pwm(q.ctl.output_mode_select)) begin
				// Staying in PWM keeps the running waveform
				d.pin = q.pin;
			end
		end

		// Flag: hardware set wins over a same-cycle write-one clear
		if (wr_sts && bus_req.wdata[`OC_STS_FLAG_BIT]) begin
			d.compare_interrupt_flag = 1'b0;
		end
		if (flag_set) begin
			d.compare_interrupt_flag = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.fault_sync1 <= 2'b11;
			q.fault_sync2 <= 2'b11;
		end else begin
			q <= d;
		end
	end

	assign bus_rdata              = q.rdata;
	assign compare_output_pin     = q.pin;
	assign compare_output_en      = q.pin_en;
	assign compare_interrupt_flag = q.compare_interrupt_flag;

endmodule

//--- include/oc_defs.svh
// Offsets, field positions and reset values of the compare channel
`ifndef OC_DEFS_SVH
`define OC_DEFS_SVH

// Register byte offsets
`define OC_ADDR_W          8
`define OC_OFF_CONTROL     8'h00
`define OC_OFF_PRIMARY     8'h04
`define OC_OFF_SECONDARY   8'h08
`define OC_OFF_T2_COUNT    8'h0C
`define OC_OFF_T2_PERIOD   8'h10
`define OC_OFF_T3_COUNT    8'h14
`define OC_OFF_T3_PERIOD   8'h18
`define OC_OFF_TB_RUN      8'h1C
`define OC_OFF_STATUS      8'h20

// Control register fields
`define OC_CTL_MODE_LSB    0
`define OC_CTL_MODE_MSB    2
`define OC_CTL_TSEL_BIT    3
`define OC_CTL_FAULT_BIT   4
`define OC_CTL_IDLE_BIT    13

// Time base run register and status register fields
`define OC_RUN_T2_BIT      0
`define OC_RUN_T3_BIT      1
`define OC_STS_FLAG_BIT    0

// Reset values
`define OC_RST_WORD        16'h0000
`define OC_COUNT_WRAP      16'h0000

// Channels up to this number follow fault input a
`define OC_LAST_FAULT_A_CH 4

`endif

//--- include/oc_pkg.sv
// Types of the output compare channel
package oc_pkg;

	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_FORCE_HIGH,
		MODE_FORCE_LOW,
		MODE_TOGGLE,
		MODE_SINGLE_PULSE,
		MODE_CONT_PULSE,
		MODE_PWM,
		MODE_PWM_FAULT
	} oc_mode_t;

	typedef enum logic [1:0] {
		PULSE_IDLE,
		PULSE_WAIT_RISE,
		PULSE_WAIT_FALL,
		PULSE_DONE
	} pulse_state_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	typedef struct packed {
		logic     idle_halt_select;
		logic     fault_status;
		logic     time_base_select;
		oc_mode_t output_mode_select;
	} ctl_t;

	typedef struct packed {
		ctl_t         ctl;
		logic [15:0]  primary_compare_value;
		logic [15:0]  secondary_compare_value;
		logic [15:0]  t2_count;
		logic [15:0]  t2_period;
		logic [15:0]  t3_count;
		logic [15:0]  t3_period;
		logic [1:0]   time_base_run;
		logic [1:0]   tb_event;
		logic [1:0]   tb_wrap;
		logic         compare_interrupt_flag;
		logic         pin;
		logic         pin_en;
		pulse_state_t pulse;
		logic [15:0]  rdata;
		logic [1:0]   fault_sync1;
		logic [1:0]   fault_sync2;
	} oc_state_t;

endpackage

//--- tb/oc_channel_sva.sv
// Port-level assertions for the compare channel
`timescale 1ns/1ps
module oc_channel_sva
	import oc_pkg::*;
#(
	parameter int CHANNEL_NUMBER = 1
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// Register port
	input wire bus_req_t    bus_req,
	input wire logic [15:0] bus_rdata,
	// Time base, idle and faults
	input wire logic [1:0]  time_base_tick,
	input wire logic        cpu_idle,
	input wire logic        fault_input_a_n,
	input wire logic        fault_input_b_n,
	// Pin and flag
	input wire logic        compare_output_pin,
	input wire logic        compare_output_en,
	input wire logic        compare_interrupt_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic ctl_wr;
	logic fault_n;
	assign ctl_wr = bus_req.wr && bus_req.addr == 8'h00;
	assign fault_n = CHANNEL_NUMBER <= 4 ? fault_input_a_n : fault_input_b_n;

	mode_off_a: assert property (
		ctl_wr && bus_req.wdata[2:0] == 3'b000 |=> !compare_output_en)
		else $error("pin still driven after disable");
	pulse_init_a: assert property (
		ctl_wr && bus_req.wdata[2:1] == 2'b10
		|=> compare_output_en && !compare_output_pin)
		else $error("pulse mode did not start low");
	force_init_a: assert property (
		ctl_wr && !bus_req.wdata[2] && bus_req.wdata[1] != bus_req.wdata[0]
		|=> compare_output_pin == $past(bus_req.wdata[1]))
		else $error("forced mode started at wrong level");
	pin_rise_a: assert property (
		$rose(compare_output_pin)
		|-> $past(time_base_tick, 2) != 2'b00 || $past(ctl_wr))
		else $error("pin rose without a count or write");
	flag_rise_a: assert property (
		$rose(compare_interrupt_flag)
		|-> $past(time_base_tick, 2) != 2'b00 || !$past(fault_n, 2))
		else $error("flag rose without a cause");
	flag_clear_a: assert property (
		bus_req.wr && bus_req.addr == 8'h20 && bus_req.wdata[0] && fault_n
		&& $past(time_base_tick) == 2'b00 |=> !compare_interrupt_flag)
		else $error("flag not cleared");
	rdata_idle_a: assert property (
		!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
		else $error("read data outside read slot");
	ctl_read_a: assert property (
		bus_req.rd && bus_req.addr == 8'h00 |=> (bus_rdata & 16'hdfe0) == 0
		&& (!bus_rdata[4] || bus_rdata[2:0] == 3'b111))
		else $error("control readback has stray bits");
endmodule

bind output_compare_pwm_channel oc_channel_sva #(
	.CHANNEL_NUMBER(CHANNEL_NUMBER)
) channel_checks (
	.clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
	.time_base_tick(time_base_tick), .cpu_idle(cpu_idle),
	.fault_input_a_n(fault_input_a_n), .fault_input_b_n(fault_input_b_n),
	.compare_output_pin(compare_output_pin),
	.compare_output_en(compare_output_en),
	.compare_interrupt_flag(compare_interrupt_flag)
);

//--- tb/pin_load.sv
// Load on the compare output, with running level counts
`timescale 1ns/1ps
module pin_load (
	// Clock and pin
	input  wire logic   clk,
	input  wire logic   pin,
	input  wire logic   en,
	// Line level and counts
	output logic        level,
	output logic [15:0] highs,
	output logic [15:0] rises
);
	logic last_q;
	// Pull-down holds the line once the channel lets go
	assign level = en ? pin : 1'b0;
	initial begin
		highs = 16'h0000;
		rises = 16'h0000;
		last_q = 1'b0;
	end
	always @(posedge clk) begin
		highs <= highs + 16'(level);
		rises <= rises + 16'(level && !last_q);
		last_q <= level;
	end
endmodule

//--- tb/output_compare_pwm_channel_test.sv
// Self-checking bench for the compare channel
`timescale 1ns/1ps
module output_compare_pwm_channel_test
	import oc_pkg::*;
;
	logic        clk;
	logic        nrst;
	bus_req_t    req;
	logic [15:0] rdata;
	logic [1:0]  tick;
	logic        idle;
	logic        flt_a_n;
	logic        flt_b_n;
	logic        pin;
	logic        en;
	logic        flag;
	logic        level;
	logic [15:0] highs;
	logic [15:0] rises;
	logic [15:0] h0;
	logic [15:0] r0;
	logic [15:0] per;
	logic [15:0] d;
	logic [15:0] pa;
	logic [31:0] seed;
	int          err_count;
	int          num_checks;
	int          cyc;
	int          i;

	output_compare_pwm_channel dut_u (
		.clk(clk), .nrst(nrst), .bus_req(req), .bus_rdata(rdata),
		.time_base_tick(tick), .cpu_idle(idle),
		.fault_input_a_n(flt_a_n), .fault_input_b_n(flt_b_n),
		.compare_output_pin(pin), .compare_output_en(en),
		.compare_interrupt_flag(flag)
	);
	pin_load load_u (
		.clk(clk), .pin(pin), .en(en),
		.level(level), .highs(highs), .rises(rises)
	);

	function automatic logic [15:0] rnd(input logic [15:0] m);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0] % m;
	endfunction
	function automatic logic [15:0] hi(input logic [15:0] v);
		return v > per ? per + 16'h0001 : v;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: w, rd: !w};
		@(posedge clk);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		#1;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		bus(1'b0, a, 16'h0000);
		chk(rdata, exp);
	endtask
	task automatic meas(input int n, input logic [15:0] eh, input logic [15:0] er);
		h0 = highs;
		r0 = rises;
		repeat (n) @(posedge clk);
		#1;
		chk(highs - h0, eh);
		chk(rises - r0, er);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial cyc = 0;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end

	initial begin
		seed = 32'h0000_3c2f;
		err_count = 0;
		num_checks = 0;
		req = '0;
		tick = 2'b11;
		idle = 1'b0;
		flt_a_n = 1'b1;
		flt_b_n = 1'b1;
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		per = 16'h0008 + rnd(16'h0020);
		rdc(8'h00, 16'h0000);
		bus(1'b1, 8'h24, 16'hffff);
		rdc(8'h24, 16'h0000);
		bus(1'b1, 8'h00, 16'hffff);
		rdc(8'h00, 16'h200f);
		bus(1'b1, 8'h00, 16'h0000);
		d = per >> 1;
		bus(1'b1, 8'h04, d);
		bus(1'b1, 8'h08, 16'h0000);
		bus(1'b1, 8'h10, per);
		bus(1'b1, 8'h18, per);
		bus(1'b1, 8'h00, 16'h0006);
		bus(1'b1, 8'h1c, 16'h0001);
		h0 = highs;
		repeat (2 * (per + 1)) @(posedge clk);
		#1;
		chk(16'(d - (highs - h0) < 2), 16'h0001);
		for (i = 0; i < 8; i++) begin
			d = i == 0 ? 16'h0000 : i == 1 ? per :
				i == 2 ? per + 16'h0001 : rnd(per + 16'h0002);
			// Second time base only from here on
			if (i == 6) begin
				bus(1'b1, 8'h1c, 16'h0002);
				bus(1'b1, 8'h00, 16'h000e);
			end
			bus(1'b1, 8'h08, d);
			bus(1'b1, 8'h04, 16'h5555);
			repeat (2 * per + 4) @(posedge clk);
			rdc(8'h04, d);
			meas(2 * (per + 1), 16'(2 * hi(d)),
				(hi(d) != 0 && hi(d) != per + 1) ? 16'h0002 : 16'h0000);
		end
		bus(1'b1, 8'h00, 16'h000f);
		flt_b_n <= 1'b0;
		repeat (6) @(posedge clk);
		rdc(8'h00, 16'h000f);
		flt_b_n <= 1'b1;
		flt_a_n <= 1'b0;
		repeat (6) @(posedge clk);
		rdc(8'h00, 16'h001f);
		chk({15'h0000, en}, 16'h0000);
		flt_a_n <= 1'b1;
		repeat (2 * per + 8) @(posedge clk);
		rdc(8'h00, 16'h000f);
		bus(1'b1, 8'h00, 16'h0000);
		bus(1'b1, 8'h1c, 16'h0003);
		pa = 16'h0001 + rnd(per >> 1);
		d = pa + 16'h0001 + rnd(per - pa);
		bus(1'b1, 8'h04, pa);
		bus(1'b1, 8'h08, d);
		tick <= 2'b00;
		bus(1'b1, 8'h20, 16'h0001);
		rdc(8'h20, 16'h0000);
		tick <= 2'b11;
		bus(1'b1, 8'h00, 16'h0005);
		repeat (per + 4) @(posedge clk);
		meas(3 * (per + 1), 16'(3 * (d - pa)), 16'h0003);
		rdc(8'h20, 16'h0001);
		bus(1'b1, 8'h00, 16'h0004);
		meas(4 * (per + 1), d - pa, 16'h0001);
		idle <= 1'b1;
		bus(1'b1, 8'h00, 16'h2004);
		meas(4 * (per + 1), 16'h0000, 16'h0000);
		idle <= 1'b0;
		bus(1'b1, 8'h00, 16'h0003);
		repeat (per + 4) @(posedge clk);
		meas(4 * (per + 1), 16'(2 * (per + 1)), 16'h0002);
		bus(1'b1, 8'h00, 16'h0001);
		repeat (per + 4) @(posedge clk);
		chk({15'h0000, level}, 16'h0001);
		bus(1'b1, 8'h00, 16'h0002);
		repeat (per + 4) @(posedge clk);
		chk({15'h0000, level}, 16'h0000);
		finish_test();
	end
endmodule
